// >>> core/serial_port_status_flags.sv
// Status flag bank for two auxiliary serial ports and the tool port
`timescale 1ns/1ps
module serial_port_status_flags
  import serial_port_status_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rstn_i,
  // Register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  output logic                   irq_o,
  // Controller scan and run state
  input  wire logic              scan_start_i,
  input  wire logic              run_rewrite_done_i,
  input  wire logic              print_active_i,
  // Port function selection
  input  wire logic [1:0]        aux1_func_i,
  input  wire logic              aux2_general_i,
  input  wire logic              tool_general_i,
  // Aux port events, index 0 = first aux port
  input  wire logic [NPORT-1:0]  tx_error_i,
  input  wire logic [NPORT-1:0]  msg_tx_req_i,
  input  wire logic [NPORT-1:0]  rx_term_i,
  input  wire logic [NPORT-1:0]  rx_rearm_i,
  input  wire logic [NPORT-1:0]  tx_complete_i,
  input  wire logic [NPORT-1:0]  tx_req_i,
  input  wire logic [NPORT-1:0]  remote_busy_i,
  input  wire logic [NPORT-1:0]  remote_start_i,
  input  wire logic [NPORT-1:0]  remote_error_i,
  input  wire logic [DATA_W-1:0] remote_err_code1_i,
  input  wire logic [DATA_W-1:0] remote_err_code2_i,
  // Tool port events
  input  wire logic              tool_rx_term_i,
  input  wire logic              tool_rx_rearm_i,
  input  wire logic              tool_tx_complete_i,
  input  wire logic              tool_tx_req_i
);

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  // Sticky flag: set wins over clear so a same-cycle event is kept
  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    sticky = set | (cur & ~clr);
  endfunction

  // ----------------------------------------------------------------
  // Mode and level flags
  // ----------------------------------------------------------------
  logic             aux1_mode_reg,  aux1_mode_next;
  logic             aux1_link_reg,  aux1_link_next;
  logic             aux2_mode_reg,  aux2_mode_next;
  logic             tool_mode_reg,  tool_mode_next;
  logic             print_busy_reg, print_busy_next;
  logic [NPORT-1:0] port_gp;

  assign port_gp = {aux2_mode_reg, aux1_mode_reg};

  always_comb begin
    aux1_mode_next  = (aux1_func_i == FUNC_GENERAL);
    aux1_link_next  = (aux1_func_i == FUNC_LINK);
    aux2_mode_next  = aux2_general_i;
    tool_mode_next  = tool_general_i;
    print_busy_next = print_active_i;
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      aux1_mode_reg  <= 1'b0;
      aux1_link_reg  <= 1'b0;
      aux2_mode_reg  <= 1'b0;
      tool_mode_reg  <= 1'b0;
      print_busy_reg <= 1'b0;
    end else begin
      aux1_mode_reg  <= aux1_mode_next;
      aux1_link_reg  <= aux1_link_next;
      aux2_mode_reg  <= aux2_mode_next;
      tool_mode_reg  <= tool_mode_next;
      print_busy_reg <= print_busy_next;
    end
  end

  // ----------------------------------------------------------------
  // Edit-in-run one-scan flag
  // ----------------------------------------------------------------
  edit_state_t edit_state_reg, edit_state_next;
  logic        edit_again_reg, edit_again_next;

  always_comb begin
    edit_state_next = edit_state_reg;
    edit_again_next = 1'b0;
    case (edit_state_reg)
      EDIT_IDLE: begin
        if (run_rewrite_done_i) begin
          edit_state_next = EDIT_ARMED;
        end
      end
      EDIT_ARMED: begin
        if (scan_start_i) begin
          edit_state_next = EDIT_SHOW;
        end
      end
      EDIT_SHOW: begin
        // A rewrite inside the shown scan earns the following scan as well
        if (scan_start_i) begin
          if (run_rewrite_done_i || edit_again_reg) begin
            edit_state_next = EDIT_SHOW;
          end else begin
            edit_state_next = EDIT_IDLE;
          end
        end else begin
          edit_again_next = edit_again_reg | run_rewrite_done_i;
        end
      end
      default: edit_state_next = EDIT_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      edit_state_reg <= EDIT_IDLE;
      edit_again_reg <= 1'b0;
    end else begin
      edit_state_reg <= edit_state_next;
      edit_again_reg <= edit_again_next;
    end
  end

  logic edit_flag;
  logic edit_rise;
  assign edit_flag = (edit_state_reg == EDIT_SHOW);
  assign edit_rise = (edit_state_next == EDIT_SHOW) && (edit_state_reg != EDIT_SHOW);

  // ----------------------------------------------------------------
  // Per aux port event flags
  // ----------------------------------------------------------------
  logic [NPORT-1:0] err_reg,  err_next;
  logic [NPORT-1:0] rx_reg,   rx_next;
  logic [NPORT-1:0] tx_reg,   tx_next;
  logic [NPORT-1:0] rdy_reg,  rdy_next;
  logic [NPORT-1:0] eend_reg, eend_next;
  logic [DATA_W-1:0] errcode_reg  [NPORT];
  logic [DATA_W-1:0] errcode_next [NPORT];
  logic [DATA_W-1:0] err_code_in  [NPORT];
  logic [NPORT-1:0] rx_set, tx_set;

  assign err_code_in[0] = remote_err_code1_i;
  assign err_code_in[1] = remote_err_code2_i;

  // Flags follow events at once, not at scan boundaries
  genvar p;
  generate
    for (p = 0; p < NPORT; p++) begin : g_port
      assign rx_set[p] = rx_term_i[p] & port_gp[p];
      assign tx_set[p] = tx_complete_i[p] & port_gp[p];
      always_comb begin
        err_next[p]  = sticky(err_reg[p], tx_error_i[p], msg_tx_req_i[p]);
        rx_next[p]   = sticky(rx_reg[p], rx_set[p], rx_rearm_i[p]);
        tx_next[p]   = sticky(tx_reg[p], tx_set[p], tx_req_i[p] & port_gp[p]);
        rdy_next[p]  = ~remote_busy_i[p];
        eend_next[p] = sticky(eend_reg[p], remote_error_i[p], remote_start_i[p]);
        errcode_next[p] = remote_error_i[p] ? err_code_in[p] : errcode_reg[p];
      end
      always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
          err_reg[p]     <= 1'b0;
          rx_reg[p]      <= 1'b0;
          tx_reg[p]      <= 1'b0;
          rdy_reg[p]     <= 1'b1;
          eend_reg[p]    <= 1'b0;
          errcode_reg[p] <= RST_ERRCODE;
        end else begin
          err_reg[p]     <= err_next[p];
          rx_reg[p]      <= rx_next[p];
          tx_reg[p]      <= tx_next[p];
          rdy_reg[p]     <= rdy_next[p];
          eend_reg[p]    <= eend_next[p];
          errcode_reg[p] <= errcode_next[p];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Tool port event flags
  // ----------------------------------------------------------------
  logic tool_rx_reg, tool_rx_next;
  logic tool_tx_reg, tool_tx_next;
  logic tool_rx_set, tool_tx_set;

  assign tool_rx_set = tool_rx_term_i & tool_mode_reg;
  assign tool_tx_set = tool_tx_complete_i & tool_mode_reg;

  always_comb begin
    tool_rx_next = sticky(tool_rx_reg, tool_rx_set, tool_rx_rearm_i);
    tool_tx_next = sticky(tool_tx_reg, tool_tx_set, tool_tx_req_i & tool_mode_reg);
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      tool_rx_reg <= 1'b0;
      tool_tx_reg <= 1'b0;
    end else begin
      tool_rx_reg <= tool_rx_next;
      tool_tx_reg <= tool_tx_next;
    end
  end

  // ----------------------------------------------------------------
  // Status words, unused positions stay zero
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] stat_a, stat_b;

  always_comb begin
    stat_a = '0;
    stat_a[A_AUX1_MODE]  = aux1_mode_reg;
    stat_a[A_PRINT_BUSY] = print_busy_reg;
    stat_a[A_EDIT_RUN]   = edit_flag;
    stat_a[A_AUX1_ERR]   = err_reg[0];
    stat_a[A_AUX1_RX]    = rx_reg[0];
    stat_a[A_AUX1_TX]    = tx_reg[0];
    stat_a[A_TOOL_RX]    = tool_rx_reg;
    stat_a[A_TOOL_TX]    = tool_tx_reg;
    stat_b = '0;
    stat_b[B_TOOL_MODE]  = tool_mode_reg;
    stat_b[B_AUX1_LINK]  = aux1_link_reg;
    stat_b[B_AUX2_MODE]  = aux2_mode_reg;
    stat_b[B_AUX1_RDY]   = rdy_reg[0];
    stat_b[B_AUX1_EEND]  = eend_reg[0];
    stat_b[B_AUX2_ERR]   = err_reg[1];
    stat_b[B_AUX2_RX]    = rx_reg[1];
    stat_b[B_AUX2_TX]    = tx_reg[1];
    stat_b[B_AUX2_RDY]   = rdy_reg[1];
    stat_b[B_AUX2_EEND]  = eend_reg[1];
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irq_stat_reg, irq_stat_next;
  logic [IRQ_W-1:0] irq_mask_reg, irq_mask_next;
  logic [IRQ_W-1:0] irq_evt;
  logic             irq_reg, irq_next;
  logic             stat_rd;

  always_comb begin
    irq_evt = '0;
    for (int i = 0; i < NPORT; i++) begin
      irq_evt[i*IRQ_PORT_STRIDE + IRQ_RX]   = rx_set[i] & ~rx_reg[i];
      irq_evt[i*IRQ_PORT_STRIDE + IRQ_TX]   = tx_set[i] & ~tx_reg[i];
      irq_evt[i*IRQ_PORT_STRIDE + IRQ_ERR]  = tx_error_i[i] & ~err_reg[i];
      irq_evt[i*IRQ_PORT_STRIDE + IRQ_EEND] = remote_error_i[i] & ~eend_reg[i];
    end
    irq_evt[IRQ_TOOL_RX] = tool_rx_set & ~tool_rx_reg;
    irq_evt[IRQ_TOOL_TX] = tool_tx_set & ~tool_tx_reg;
    irq_evt[IRQ_EDIT]    = edit_rise;
  end

  assign stat_rd = rd_i & hit(addr_i, ADDR_IRQ_STAT);

  always_comb begin
    // Event in the reading cycle survives the clear
    irq_stat_next = irq_evt | (stat_rd ? '0 : irq_stat_reg);
    irq_mask_next = irq_mask_reg;
    if (wr_i && hit(addr_i, ADDR_IRQ_MASK)) begin
      irq_mask_next = wdata_i[IRQ_W-1:0];
    end
    irq_next = |(irq_stat_next & irq_mask_next);
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= RST_MASK;
      irq_reg      <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg      <= irq_next;
    end
  end

  assign irq_o = irq_reg;

  // ----------------------------------------------------------------
  // Read path; writes other than the mask are dropped
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rdata_reg, rdata_next;

  always_comb begin
    rdata_next = '0;
    if (rd_i) begin
      case (addr_i)
        ADDR_STAT_A:   rdata_next = stat_a;
        ADDR_STAT_B:   rdata_next = stat_b;
        ADDR_ERRCODE1: rdata_next = errcode_reg[0];
        ADDR_ERRCODE2: rdata_next = errcode_reg[1];
        ADDR_IRQ_STAT: rdata_next = {{(DATA_W-IRQ_W){1'b0}}, irq_stat_reg};
        ADDR_IRQ_MASK: rdata_next = {{(DATA_W-IRQ_W){1'b0}}, irq_mask_reg};
        default:       rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;

endmodule

// >>> core/serial_port_status_pkg.sv
// Constants for the serial port status flag bank
package serial_port_status_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int NPORT  = 2;
  // Register word offsets
  localparam logic [3:0] ADDR_STAT_A   = 4'h0;
  localparam logic [3:0] ADDR_STAT_B   = 4'h1;
  localparam logic [3:0] ADDR_ERRCODE1 = 4'h2;
  localparam logic [3:0] ADDR_ERRCODE2 = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
  // Status word A bit positions
  localparam int A_AUX1_MODE  = 2;
  localparam int A_PRINT_BUSY = 3;
  localparam int A_EDIT_RUN   = 4;
  localparam int A_AUX1_ERR   = 7;
  localparam int A_AUX1_RX    = 8;
  localparam int A_AUX1_TX    = 9;
  localparam int A_TOOL_RX    = 14;
  localparam int A_TOOL_TX    = 15;
  // Status word B bit positions
  localparam int B_TOOL_MODE  = 0;
  localparam int B_AUX1_LINK  = 1;
  localparam int B_AUX2_MODE  = 2;
  localparam int B_AUX1_RDY   = 4;
  localparam int B_AUX1_EEND  = 5;
  localparam int B_AUX2_ERR   = 7;
  localparam int B_AUX2_RX    = 8;
  localparam int B_AUX2_TX    = 9;
  localparam int B_AUX2_RDY   = 10;
  localparam int B_AUX2_EEND  = 11;
  // Interrupt status bits: per aux port base + offset, then tool and edit
  localparam int IRQ_PORT_STRIDE = 4;
  localparam int IRQ_RX   = 0;
  localparam int IRQ_TX   = 1;
  localparam int IRQ_ERR  = 2;
  localparam int IRQ_EEND = 3;
  localparam int IRQ_TOOL_RX = 8;
  localparam int IRQ_TOOL_TX = 9;
  localparam int IRQ_EDIT    = 10;
  localparam int IRQ_W       = 11;
  // Reset values
  localparam logic [DATA_W-1:0] RST_ERRCODE = 16'h0000;
  localparam logic [IRQ_W-1:0]  RST_MASK    = 11'h000;
  // First aux port function select
  localparam logic [1:0] FUNC_GENERAL = 2'h0;
  localparam logic [1:0] FUNC_HOST    = 2'h1;
  localparam logic [1:0] FUNC_LINK    = 2'h2;
  typedef enum logic [2:0] {
    EDIT_IDLE  = 3'b001,
    EDIT_ARMED = 3'b010,
    EDIT_SHOW  = 3'b100
  } edit_state_t;
endpackage

// >>> sim/serial_port_status_checker.sv
// Port-level assertions for the serial port status flag bank
`timescale 1ns/1ps
module serial_port_status_checker
  import serial_port_status_pkg::*;
(
  input wire logic              mclk_i,
  input wire logic              rstn_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic              rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic              print_active_i,
  input wire logic [1:0]        aux1_func_i,
  input wire logic              tool_general_i,
  input wire logic [NPORT-1:0]  tx_error_i,
  input wire logic [NPORT-1:0]  msg_tx_req_i,
  input wire logic [NPORT-1:0]  remote_busy_i,
  input wire logic [NPORT-1:0]  remote_error_i,
  input wire logic [DATA_W-1:0] remote_err_code1_i
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_rd(logic [ADDR_W-1:0] a);
    rd_i && addr_i == a;
  endsequence
  // Flags may move mid-scan, so only a steady source is compared
  property p_lvl(logic [ADDR_W-1:0] a, logic src, int b);
    $past(rstn_i) && $stable(src) ##0 s_rd(a) |=> rdata_o[b] == $past(src);
  endproperty
  a_idle_read_zero: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data not zero outside a read");
  a_unused_a_zero: assert property (s_rd(ADDR_STAT_A) |=> (rdata_o & 16'h3c63) == 0)
    else $error("unused bit set in status word A");
  a_unused_b_zero: assert property (s_rd(ADDR_STAT_B) |=> (rdata_o & 16'hf048) == 0)
    else $error("unused bit set in status word B");
  a_aux1_mode: assert property (p_lvl(ADDR_STAT_A, aux1_func_i == FUNC_GENERAL, A_AUX1_MODE))
    else $error("first aux mode flag wrong");
  a_print_busy: assert property (p_lvl(ADDR_STAT_A, print_active_i, A_PRINT_BUSY))
    else $error("print busy flag wrong");
  a_tool_mode: assert property (p_lvl(ADDR_STAT_B, tool_general_i, B_TOOL_MODE))
    else $error("tool mode flag wrong");
  a_aux1_link: assert property (p_lvl(ADDR_STAT_B, aux1_func_i == FUNC_LINK, B_AUX1_LINK))
    else $error("link flag wrong");
  a_ready_busy: assert property (p_lvl(ADDR_STAT_B, !remote_busy_i[0], B_AUX1_RDY))
    else $error("ready flag wrong");
  a_err_code_kept: assert property (remote_error_i[0] ##1 !remote_error_i[0] [*2]
    ##0 s_rd(ADDR_ERRCODE1) |=> rdata_o == $past(remote_err_code1_i, 3))
    else $error("error code word wrong");
  a_comm_err_set: assert property (tx_error_i[0] ##1 !msg_tx_req_i[0]
    ##1 s_rd(ADDR_STAT_A) |=> rdata_o[A_AUX1_ERR])
    else $error("comm error flag not set");
  a_comm_err_clear: assert property (msg_tx_req_i[0] && !tx_error_i[0]
    ##1 !tx_error_i[0] ##1 s_rd(ADDR_STAT_A) |=> !rdata_o[A_AUX1_ERR])
    else $error("comm error flag not cleared");
endmodule
bind serial_port_status_flags serial_port_status_checker i_serial_port_status_checker (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .print_active_i(print_active_i), .aux1_func_i(aux1_func_i),
  .tool_general_i(tool_general_i), .tx_error_i(tx_error_i), .msg_tx_req_i(msg_tx_req_i),
  .remote_busy_i(remote_busy_i), .remote_error_i(remote_error_i),
  .remote_err_code1_i(remote_err_code1_i));

// >>> sim/serial_port_status_flags_bench.sv
// Self-checking bench for the serial port status flag bank
`timescale 1ns/1ps
module serial_port_status_flags_bench;
  import serial_port_status_pkg::*;
  logic              mclk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, irq;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0, code1 = '0, code2 = '0, rdata_o, d;
  logic [1:0]        func = 2'h3, terr = '0, mreq = '0, rxt = '0, rxr = '0, txc = '0;
  logic [1:0]        txq = '0, rbusy = '0, rgo = '0, rerr = '0;
  logic              scan = 0, rew = 0, prn = 0, a2g = 0, tg = 0, trxt = 0, trxr = 0;
  logic              ttxc = 0, ttxq = 0;
  int                n_fail = 0, tests_run = 0;
  serial_port_status_flags i_serial_port_status_flags (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq), .scan_start_i(scan),
    .run_rewrite_done_i(rew), .print_active_i(prn), .aux1_func_i(func),
    .aux2_general_i(a2g), .tool_general_i(tg), .tx_error_i(terr), .msg_tx_req_i(mreq),
    .rx_term_i(rxt), .rx_rearm_i(rxr), .tx_complete_i(txc), .tx_req_i(txq),
    .remote_busy_i(rbusy), .remote_start_i(rgo), .remote_error_i(rerr),
    .remote_err_code1_i(code1), .remote_err_code2_i(code2), .tool_rx_term_i(trxt),
    .tool_rx_rearm_i(trxr), .tool_tx_complete_i(ttxc), .tool_tx_req_i(ttxq));
  always #5 mclk_i = ~mclk_i;
  //----------------------------------------
  // Bus and compare helpers
  //----------------------------------------
  task automatic chk(input logic [DATA_W-1:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge mclk_i);
    wr_i    <= w;
    rd_i    <= !w;
    addr_i  <= a;
    wdata_i <= v;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m, e);
    bus(1'b0, a, 16'h0000);
    chk(d & m, e);
  endtask
  task automatic scanp;
    @(posedge mclk_i) scan <= 1'b1;
    @(posedge mclk_i) scan <= 1'b0;
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  //----------------------------------------
  // Scenarios
  //----------------------------------------
  task automatic t_reset;
    rchk(ADDR_STAT_A, 16'hffff, 16'h0000);
    rchk(ADDR_STAT_B, 16'hffff, 16'h0410);
    rchk(ADDR_ERRCODE1, 16'hffff, RST_ERRCODE);
    rchk(4'h9, 16'hffff, 16'h0000);
    bus(1'b1, ADDR_STAT_A, 16'hffff);
    bus(1'b1, ADDR_IRQ_MASK, 16'hffff);
    rchk(ADDR_STAT_A, 16'hffff, 16'h0000);
    rchk(ADDR_IRQ_MASK, 16'hffff, 16'h07ff);
    $display("test reset done");
  endtask
  task automatic t_modes;
    for (int f = 0; f < 4; f++) begin
      @(posedge mclk_i) func <= f[1:0];
      tg  <= f[0];
      a2g <= f[1];
      rchk(ADDR_STAT_A, 16'h0004, {13'h0, f == 0, 2'h0});
      rchk(ADDR_STAT_B, 16'h0007, {13'h0, f[1], f == 2, f[0]});
    end
    @(posedge mclk_i) func <= FUNC_GENERAL;
    tg  <= 1'b1;
    a2g <= 1'b1;
    $display("test modes done");
  endtask
  task automatic t_levels;
    @(posedge mclk_i) prn <= 1'b1;
    rbusy <= 2'b01;
    rchk(ADDR_STAT_A, 16'h0008, 16'h0008);
    rchk(ADDR_STAT_B, 16'h0410, 16'h0400);
    @(posedge mclk_i) prn <= 1'b0;
    rbusy <= 2'b10;
    rchk(ADDR_STAT_A, 16'h0008, 16'h0000);
    rchk(ADDR_STAT_B, 16'h0410, 16'h0010);
    @(posedge mclk_i) rbusy <= 2'b00;
    $display("test levels done");
  endtask
  task automatic t_rxtx;
    @(posedge mclk_i) {rxt, txc, trxt, ttxc} <= 6'h3f;
    @(posedge mclk_i) {rxt, txc, trxt, ttxc} <= 6'h00;
    rchk(ADDR_STAT_A, 16'hc300, 16'hc300);
    rchk(ADDR_STAT_B, 16'h0300, 16'h0300);
    @(posedge mclk_i) {txq, ttxq} <= 3'h7;
    @(posedge mclk_i) {txq, ttxq} <= 3'h0;
    rchk(ADDR_STAT_A, 16'hc300, 16'h4100);
    rchk(ADDR_STAT_B, 16'h0300, 16'h0100);
    @(posedge mclk_i) {func, rxr, trxr} <= 5'b01011;
    // Terminator while in host protocol must not mark reception
    @(posedge mclk_i) {rxt, rxr, trxr} <= 5'b01000;
    @(posedge mclk_i) {func, rxt} <= 4'h0;
    rchk(ADDR_STAT_A, 16'h4100, 16'h0000);
    $display("test rxtx done");
  endtask
  task automatic t_remote;
    @(posedge mclk_i) {rerr, code1, code2} <= {2'b11, 16'h1234, 16'h0bad};
    @(posedge mclk_i) {rerr, code1, code2} <= '0;
    rchk(ADDR_ERRCODE1, 16'hffff, 16'h1234);
    rchk(ADDR_ERRCODE2, 16'hffff, 16'h0bad);
    rchk(ADDR_STAT_B, 16'h0820, 16'h0820);
    @(posedge mclk_i) rgo <= 2'b01;
    @(posedge mclk_i) rgo <= 2'b00;
    rchk(ADDR_STAT_B, 16'h0820, 16'h0800);
    $display("test remote done");
  endtask
  task automatic t_edit;
    @(posedge mclk_i) rew <= 1'b1;
    @(posedge mclk_i) rew <= 1'b0;
    rchk(ADDR_STAT_A, 16'h0010, 16'h0000);
    scanp();
    rchk(ADDR_STAT_A, 16'h0010, 16'h0010);
    // A rewrite inside the shown scan must carry the flag into the next one
    @(posedge mclk_i) rew <= 1'b1;
    @(posedge mclk_i) rew <= 1'b0;
    scanp();
    rchk(ADDR_STAT_A, 16'h0010, 16'h0010);
    scanp();
    rchk(ADDR_STAT_A, 16'h0010, 16'h0000);
    $display("test edit done");
  endtask
  task automatic t_err_irq;
    bus(1'b0, ADDR_IRQ_STAT, 16'h0000);
    bus(1'b1, ADDR_IRQ_MASK, 16'h0004);
    for (int p = 0; p < 2; p++) begin
      @(posedge mclk_i) terr <= 2'b01 << p;
      @(posedge mclk_i) terr <= 2'b00;
      #1 chk({15'h0, irq}, {15'h0, p == 0});
      rchk(p ? ADDR_STAT_B : ADDR_STAT_A, 16'h0080, 16'h0080);
      rchk(ADDR_IRQ_STAT, 16'hffff, 16'h0004 << (4 * p));
      chk({15'h0, irq}, 16'h0000);
      @(posedge mclk_i) mreq <= 2'b01 << p;
      @(posedge mclk_i) mreq <= 2'b00;
      rchk(p ? ADDR_STAT_B : ADDR_STAT_A, 16'h0080, 16'h0000);
    end
    $display("test error and interrupt done");
  endtask
  initial begin
    repeat (20) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_modes();
    t_levels();
    t_rxtx();
    t_remote();
    t_edit();
    t_err_irq();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_fail++;
    close_out();
  end
endmodule
